// ### core/clock_divider.sv
// One peripheral clock divider with integer and optional fractional part
`timescale 1ns/1ns
module clock_divider
  import sysres_pkg::*;
#(
  parameter int unsigned INT_W = 16,
  parameter int unsigned FRAC_W = 5
)(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic [INT_W-1:0] int_div,
  input wire logic [FRAC_W-1:0] frac_div,
  output logic clk_en
);
  logic [INT_W-1:0] cnt_q;
  logic [FRAC_W:0] acc_q;
  logic [FRAC_W:0] acc_sum;
  logic extra;
  logic stretch_q;

  // Fractional accumulator adds one extra cycle to the next period when it overflows
  assign acc_sum = {1'b0, acc_q[FRAC_W-1:0]} + {1'b0, frac_div};
  assign extra = acc_sum[FRAC_W];

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= '0;
      acc_q <= '0;
      stretch_q <= 1'b0;
      clk_en <= 1'b0;
    end
    else if (!enable)
    begin
      cnt_q <= '0;
      acc_q <= '0;
      stretch_q <= 1'b0;
      clk_en <= 1'b0;
    end
    else if (cnt_q >= int_div && stretch_q)
    begin
      stretch_q <= 1'b0;
      clk_en <= 1'b0;
    end
    else if (cnt_q >= int_div)
    begin
      cnt_q <= '0;
      acc_q <= acc_sum;
      stretch_q <= extra;
      clk_en <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + INT_W'(1);
      clk_en <= 1'b0;
    end
  end
endmodule // clock_divider

// ### core/system_resources_controller.sv
// System-resources controller: power modes, resets, watchdog, clocks, debug lock
//
// Behaviour
// - Debug on after reset, firmware can disable
// - Once disabled, debug stays off until erase
// - Max security permanently blocks all test ports
// - Three power modes, Active clocks CPU once Deep wake settle ends and no reset
// - Sleep gates CPU clock only, fast clock stays on; instant wake
// - Deep Sleep stops fast clock; wake within 35us
// - Wake unit restarts processor from Deep Sleep
// - Hold modes until supply good; brown-out resets
// - Glitch-free, synchronised clock source switching
// - Eighteen dividers: 12 int16, 5 frac16, 1 frac24
// - Main oscillator 24 MHz, 24..48 in 4 MHz
// - Watchdog on low-power osc, resets on timeout
// - Watchdog reset logged in cause record
// - Cause record survives the reset it describes
// - Several reset sources, asynchronous, known state
`timescale 1ns/1ns
module system_resources_controller
  import sysres_pkg::*;
#(
  parameter int unsigned WAKE_CYC = DS_WAKE_CYC
)(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic external_reset_pin_n,
  input wire logic supply_good,
  input wire logic brownout,
  input wire logic sw_reset_req,
  input wire logic [CAUSE_W-1:0] cause_clear,
  output logic [CAUSE_W-1:0] reset_cause,
  output logic sys_reset,
  input wire logic sleep_req,
  input wire logic deep_req,
  input wire logic wake_event,
  output power_mode_e power_mode,
  output logic cpu_clk_en,
  output logic hf_clk_en,
  output logic cpu_power_on,
  output logic wake_ready,
  input wire logic low_power_osc_tick,
  input wire logic wdog_enable,
  input wire logic [WDOG_W-1:0] wdog_limit,
  input wire logic wdog_service,
  input wire logic debug_disable,
  input wire logic device_erase,
  input wire logic security_max,
  output logic debug_enabled,
  output logic security_locked,
  input wire logic [2:0] osc_freq_sel,
  output logic [2:0] osc_freq,
  input wire logic clk_src_sel,
  output logic clk_src_active,
  input wire logic [NUM_DIV-1:0] div_enable,
  input wire logic [NUM_DIV*DIV_WIDE_W-1:0] div_int,
  input wire logic [NUM_DIV*DIV_FRAC_W-1:0] div_frac,
  output logic [NUM_DIV-1:0] div_clk_en
);
  logic [3:0] pulse_q;
  logic [WDOG_W-1:0] wdog_q;
  logic wdog_fire;
  logic ext_fire;
  logic [CAUSE_W-1:0] cause_set;
  logic [15:0] wake_q;
  logic sel_s1_q, sel_s2_q;
  logic switching_q;

  assign ext_fire = !external_reset_pin_n;
  assign wdog_fire = wdog_enable && low_power_osc_tick && (wdog_q >= wdog_limit);

  // Cause record runs on top-level rst only, so internal resets keep it
  assign cause_set = {wdog_fire, brownout, sw_reset_req, ext_fire};
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      reset_cause <= '0;
    else
      reset_cause <= cause_set | (reset_cause & ~cause_clear);
  end

  // Any source stretches into a fixed internal reset pulse
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      pulse_q <= RST_PULSE_CYC;
    else if (|cause_set)
      pulse_q <= RST_PULSE_CYC;
    else if (pulse_q != 4'h0)
      pulse_q <= pulse_q - 4'h1;
  end
  assign sys_reset = (pulse_q != 4'h0) || (|cause_set);

  // Watchdog counts low-power oscillator ticks, runs in every mode
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      wdog_q <= '0;
    else if (wdog_service || !wdog_enable || wdog_fire)
      wdog_q <= '0;
    else if (low_power_osc_tick)
      wdog_q <= wdog_q + WDOG_W'(1);
  end

  // Power mode sequencing
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      power_mode <= MODE_ACTIVE;
      wake_q <= '0;
    end
    else if (sys_reset || !supply_good)
    begin
      power_mode <= MODE_ACTIVE;
      wake_q <= '0;
    end
    else
    begin
      case (power_mode)
        MODE_ACTIVE:
          if (wake_q != 16'h0)
            wake_q <= wake_q - 16'h1;
          else if (deep_req)
            power_mode <= MODE_DEEP;
          else if (sleep_req)
            power_mode <= MODE_SLEEP;
        MODE_SLEEP:
          if (wake_event)
            power_mode <= MODE_ACTIVE;
        MODE_DEEP:
          if (wake_event)
          begin
            power_mode <= MODE_ACTIVE;
            wake_q <= 16'(DS_SETTLE_CYC < WAKE_CYC ? DS_SETTLE_CYC : WAKE_CYC - 1);
          end
        default:
          power_mode <= MODE_ACTIVE;
      endcase
    end
  end
  assign hf_clk_en = (power_mode != MODE_DEEP);
  assign cpu_power_on = (power_mode != MODE_DEEP) && !sys_reset;
  assign wake_ready = (power_mode == MODE_ACTIVE) && (wake_q == 16'h0);
  assign cpu_clk_en = wake_ready && supply_good && !sys_reset;

  // Debug lock: only an erase brings debug back
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      security_locked <= 1'b0;
    else if (security_max)
      security_locked <= 1'b1;
  end
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      debug_enabled <= 1'b1;
    else if (security_max || security_locked)
      debug_enabled <= 1'b0;
    else if (debug_disable)
      debug_enabled <= 1'b0;
    else if (device_erase)
      debug_enabled <= 1'b1;
  end

  // Main oscillator setting ignores codes above the legal range and keeps its value
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      osc_freq <= OSC_FREQ_RST;
    else if (osc_freq_sel <= OSC_FREQ_MAX)
      osc_freq <= osc_freq_sel;
  end

  // Source select is synchronised and applied only while dividers are idle
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sel_s1_q <= 1'b0;
      sel_s2_q <= 1'b0;
    end
    else
    begin
      sel_s1_q <= clk_src_sel;
      sel_s2_q <= sel_s1_q;
    end
  end
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      clk_src_active <= 1'b0;
      switching_q <= 1'b0;
    end
    else if (sel_s2_q != clk_src_active && !switching_q)
      switching_q <= 1'b1;
    else if (switching_q)
    begin
      clk_src_active <= sel_s2_q;
      switching_q <= 1'b0;
    end
  end

  // Divider bank
  for (genvar i = 0; i < NUM_DIV; i++)
  begin : g_div
    localparam int unsigned IW = (i == NUM_DIV - 1) ? DIV_WIDE_W : DIV_INT_W;
    localparam int unsigned FW = (i < NUM_INT_DIV) ? 1 : DIV_FRAC_W;
    logic [FW-1:0] frac;
    assign frac = (i < NUM_INT_DIV) ? '0 : div_frac[i*DIV_FRAC_W +: FW];
    clock_divider #(.INT_W(IW), .FRAC_W(FW)) u_div (
      .core_clk(core_clk),
      .rst(rst),
      .enable(div_enable[i] && hf_clk_en && !switching_q),
      .int_div(div_int[i*DIV_WIDE_W +: IW]),
      .frac_div(frac),
      .clk_en(div_clk_en[i])
    );
  end

  AST_DEBUG_STAYS_OFF: assert property (@(posedge core_clk) disable iff (rst)
    !debug_enabled && !device_erase |=> !debug_enabled)
    else $error("debug re-enabled without erase");
  AST_LOCK_BLOCKS: assert property (@(posedge core_clk) disable iff (rst)
    security_locked |-> ##1 (security_locked && !debug_enabled))
    else $error("security lock released");
  AST_SLEEP_GATES: assert property (@(posedge core_clk) disable iff (rst)
    power_mode == MODE_SLEEP |-> !cpu_clk_en)
    else $error("cpu clocked in sleep");
  AST_SLEEP_WAKE: assert property (@(posedge core_clk) disable iff (rst)
    power_mode == MODE_SLEEP && wake_event |=> power_mode == MODE_ACTIVE)
    else $error("sleep wake late");
  AST_DEEP_WAKE: assert property (@(posedge core_clk) disable iff (rst)
    power_mode == MODE_DEEP && wake_event && supply_good |-> ##[1:350] wake_ready)
    else $error("deep sleep wake too slow");
  AST_DEEP_HF_OFF: assert property (@(posedge core_clk) disable iff (rst)
    power_mode == MODE_DEEP |-> !hf_clk_en && !cpu_power_on)
    else $error("fast clock on in deep sleep");
  AST_WDOG_CAUSE: assert property (@(posedge core_clk) disable iff (rst)
    wdog_fire |=> reset_cause[CAUSE_WDOG] && sys_reset)
    else $error("watchdog reset not logged");
  AST_CAUSE_STICKY: assert property (@(posedge core_clk) disable iff (rst)
    reset_cause[CAUSE_SW] && !cause_clear[CAUSE_SW] |=> reset_cause[CAUSE_SW])
    else $error("cause bit lost");
  AST_SERVICE: assert property (@(posedge core_clk) disable iff (rst)
    wdog_service |=> wdog_q == '0)
    else $error("service did not restart count");
  AST_SUPPLY_HOLD: assert property (@(posedge core_clk) disable iff (rst)
    !supply_good |-> !cpu_clk_en ##1 (power_mode == MODE_ACTIVE))
    else $error("mode entered on bad supply");
endmodule // system_resources_controller

// ### shared/sysres_pkg.sv
// Constants and types for the system-resources controller
package sysres_pkg;
  // Core clock rate
  localparam int unsigned CORE_CLK_HZ = 10_000_000;
  localparam int unsigned CORE_CLK_NS = 100;
  // Deep Sleep wake-up limit in ns; longest time so it rounds down
  localparam int unsigned DS_WAKE_MAX_NS = 35_000;
  localparam int unsigned DS_WAKE_CYC = DS_WAKE_MAX_NS / CORE_CLK_NS;
  // High-speed clock restart settle time used inside the wake window
  localparam int unsigned DS_SETTLE_CYC = DS_WAKE_CYC / 2;
  // Divider bank layout
  localparam int unsigned NUM_DIV = 18;
  localparam int unsigned NUM_INT_DIV = 12;
  localparam int unsigned NUM_FRAC16_DIV = 5;
  localparam int unsigned DIV_INT_W = 16;
  localparam int unsigned DIV_WIDE_W = 24;
  localparam int unsigned DIV_FRAC_W = 5;
  // Main oscillator frequency code: MHz = 24 + 4 * code, codes 0..6
  localparam logic [2:0] OSC_FREQ_RST = 3'h0;
  localparam logic [2:0] OSC_FREQ_MAX = 3'h6;
  localparam int unsigned OSC_BASE_MHZ = 24;
  localparam int unsigned OSC_STEP_MHZ = 4;
  // Reset-cause bit positions
  localparam int unsigned CAUSE_W = 4;
  localparam int unsigned CAUSE_EXT = 0;
  localparam int unsigned CAUSE_SW = 1;
  localparam int unsigned CAUSE_BOD = 2;
  localparam int unsigned CAUSE_WDOG = 3;
  // Watchdog
  localparam int unsigned WDOG_W = 16;
  localparam logic [15:0] WDOG_LIMIT_RST = 16'hFFFF;
  // Internal reset pulse length in cycles
  localparam logic [3:0] RST_PULSE_CYC = 4'h8;

  typedef enum logic [1:0] {MODE_ACTIVE, MODE_SLEEP, MODE_DEEP} power_mode_e;
endpackage

// ### testbench/ext_reset_source.sv
// Board-side reset source driving the external reset pin
`timescale 1ns/1ns
module ext_reset_source (
  input wire logic core_clk,
  input wire logic push,
  output logic pin_n
);
  logic hold_q;
  always_ff @(posedge core_clk)
    hold_q <= push;
  // Released pin sits at the pull-up level
  assign pin_n = hold_q ? 1'b0 : 1'b1;
endmodule // ext_reset_source

// ### testbench/system_resources_controller_tb_top.sv
// Self-checking bench for the system-resources controller
`timescale 1ns/1ns
module system_resources_controller_tb_top;
  import sysres_pkg::*;
  logic core_clk = 0, rst = 1, push, supply_good, brownout, sw_reset_req;
  logic sleep_req, deep_req, wake_event, low_power_osc_tick, wdog_enable, wdog_service;
  logic debug_disable, device_erase, security_max, clk_src_sel, pin_n;
  logic sys_reset, cpu_clk_en, hf_clk_en, cpu_power_on, wake_ready;
  logic debug_enabled, security_locked, clk_src_active;
  logic [CAUSE_W-1:0] cause_clear, reset_cause;
  logic [WDOG_W-1:0] wdog_limit;
  logic [2:0] osc_freq_sel, osc_freq;
  logic [NUM_DIV-1:0] div_enable, div_clk_en;
  logic [NUM_DIV*DIV_WIDE_W-1:0] div_int;
  logic [NUM_DIV*DIV_FRAC_W-1:0] div_frac;
  power_mode_e power_mode;
  int n_mismatch = 0, checks = 0, ncyc = 0, k, n0, n12, n17;
  always #50 core_clk = ~core_clk;
  ext_reset_source i_ext_reset_source (.core_clk, .push, .pin_n);
  system_resources_controller i_system_resources_controller (
    .core_clk, .rst, .external_reset_pin_n(pin_n), .supply_good, .brownout,
    .sw_reset_req, .cause_clear, .reset_cause, .sys_reset, .sleep_req, .deep_req,
    .wake_event, .power_mode, .cpu_clk_en, .hf_clk_en, .cpu_power_on, .wake_ready,
    .low_power_osc_tick, .wdog_enable, .wdog_limit, .wdog_service, .debug_disable,
    .device_erase, .security_max, .debug_enabled, .security_locked, .osc_freq_sel,
    .osc_freq, .clk_src_sel, .clk_src_active, .div_enable, .div_int, .div_frac,
    .div_clk_en);
  task automatic close_out;
    if (n_mismatch == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(2);
  endtask
  task automatic ticks(input int n);
    repeat (n) pulse(low_power_osc_tick);
  endtask
  // Wait for the internal reset stretch to end
  task automatic settle;
    k = 0;
    while (sys_reset !== 1'b0 && k < 40)
    begin
      cyc(1);
      k++;
    end
    cyc(1);
  endtask
  always @(posedge core_clk)
  begin
    ncyc++;
    if (ncyc == 6000)
    begin
      n_mismatch++;
      close_out;
    end
  end
  initial
  begin
    {push, brownout, sw_reset_req, sleep_req, deep_req, wake_event} = '0;
    {low_power_osc_tick, wdog_enable, wdog_service, debug_disable} = '0;
    {device_erase, security_max, clk_src_sel} = '0;
    supply_good = 1'b1;
    cause_clear = '0;
    wdog_limit = 16'h0004;
    osc_freq_sel = 3'h0;
    div_enable = '0;
    div_int = '0;
    div_frac = '0;
    cyc(16);
    rst = 1'b0;
    cyc(9);
    chk(reset_cause, 0);
    chk(debug_enabled, 1);
    chk(power_mode, MODE_ACTIVE);
    chk(cpu_clk_en, 1);
    chk(osc_freq, OSC_FREQ_RST);
    osc_freq_sel = OSC_FREQ_MAX;
    cyc(2);
    chk(osc_freq, 3'h6);
    osc_freq_sel = 3'h7;
    cyc(2);
    chk(osc_freq, 3'h6);
    sleep_req = 1'b1;
    cyc(2);
    sleep_req = 1'b0;
    chk(power_mode, MODE_SLEEP);
    chk({cpu_clk_en, hf_clk_en}, 2'b01);
    pulse(wake_event);
    chk(power_mode, MODE_ACTIVE);
    chk(cpu_clk_en, 1);
    deep_req = 1'b1;
    cyc(2);
    deep_req = 1'b0;
    chk(power_mode, MODE_DEEP);
    chk({hf_clk_en, cpu_power_on}, 2'b00);
    pulse(wake_event);
    chk(cpu_power_on, 1);
    // Wake event was taken two and a half cycles ago; the limit counts from there
    k = 0;
    while (wake_ready !== 1'b1 && k < DS_WAKE_CYC - 2)
    begin
      cyc(1);
      k++;
    end
    chk(wake_ready, 1);
    supply_good = 1'b0;
    sleep_req = 1'b1;
    cyc(3);
    chk(power_mode, MODE_ACTIVE);
    sleep_req = 1'b0;
    supply_good = 1'b1;
    for (int s = 0; s < 3; s++)
    begin
      push = (s == 0);
      sw_reset_req = (s == 1);
      brownout = (s == 2);
      cyc(3);
      chk(sys_reset, 1);
      {push, sw_reset_req, brownout} = '0;
      settle;
      chk(reset_cause, 4'h1 << s);
      cause_clear = 4'hF;
      cyc(1);
      cause_clear = '0;
      chk(reset_cause, 0);
    end
    wdog_enable = 1'b1;
    ticks(3);
    pulse(wdog_service);
    ticks(3);
    chk({reset_cause, sys_reset}, 0);
    ticks(3);
    wdog_enable = 1'b0;
    settle;
    chk(reset_cause, 4'h1 << CAUSE_WDOG);
    clk_src_sel = 1'b1;
    k = 0;
    while (clk_src_active !== 1'b1 && k < 8)
    begin
      cyc(1);
      k++;
    end
    chk(clk_src_active, 1);
    div_int[15:0] = 16'h0002;
    div_int[12*DIV_WIDE_W +: DIV_INT_W] = 16'h0001;
    div_frac[12*DIV_FRAC_W +: DIV_FRAC_W] = 5'h10;
    div_int[17*DIV_WIDE_W +: DIV_WIDE_W] = 24'h00_0001;
    div_enable = 18'h2_1001;
    cyc(8);
    n0 = 0;
    n12 = 0;
    n17 = 0;
    repeat (30)
    begin
      cyc(1);
      n0 += div_clk_en[0];
      n12 += div_clk_en[12];
      n17 += div_clk_en[17];
    end
    chk(n0, 10);
    chk(n12, 12);
    chk(n17, 15);
    pulse(debug_disable);
    chk(debug_enabled, 0);
    pulse(device_erase);
    chk(debug_enabled, 1);
    pulse(security_max);
    chk({security_locked, debug_enabled}, 2'b10);
    pulse(device_erase);
    chk({security_locked, debug_enabled}, 2'b10);
    close_out;
  end
endmodule // system_resources_controller_tb_top
